// ===== verilog/lpmc_pkg.sv
package lpmc_pkg;

   localparam int unsigned REF_CLK_MHZ    = 100;
   localparam int unsigned WAIT_RESTART_NS = 10000;
   localparam int unsigned WAIT_RESTART_CYC = (WAIT_RESTART_NS * REF_CLK_MHZ) / 1000 - 1;
   localparam int unsigned BACKUP_SEQ_CYC = 16;

   localparam int unsigned NUM_WAKE_PINS = 16;

   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_MODE    = 8'h04;
   localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_SRCEN   = 8'h10;

   localparam int unsigned CTRL_REG_OFF_BIT  = 0;
   localparam int unsigned CTRL_WAIT_REQ_BIT = 1;

   localparam int unsigned MODE_LPSEL_BIT    = 0;
   localparam int unsigned MODE_DEEP_BIT     = 1;
   localparam int unsigned MODE_ONEXIT_BIT   = 2;
   localparam int unsigned MODE_PORDIS_BIT   = 3;
   localparam int unsigned MODE_FLASH_LOW_POWER_SELECT_LSB     = 4;

   localparam int unsigned SRC_FORCED_WAKEUP_PIN_BIT   = 0;
   localparam int unsigned SRC_SM_BIT     = 1;
   localparam int unsigned SRC_TAMPER_BIT = 2;
   localparam int unsigned SRC_RTC_BIT    = 3;
   localparam int unsigned SRC_RTT_BIT    = 4;

   localparam logic [1:0] FLASH_STANDBY = 2'h0;
   localparam logic [1:0] FLASH_DEEP_PD = 2'h1;
   localparam logic [1:0] FLASH_IDLE    = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_SLEEP,
      ST_WAIT,
      ST_RESTART,
      ST_BACKUP,
      ST_POWERUP
   } lpmc_state_t;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } lpmc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } lpmc_axi_rsp_t;

   typedef struct packed {
      logic [NUM_WAKE_PINS-1:0] wakePin;
      logic                     forcedWakeupPin;
      logic                     tamperEvent;
      logic                     rtcAlarm;
      logic                     rttAlarm;
      logic                     ioSupplyPresent;
      logic                     ioSupplyLow;
   } lpmc_wake_t;

   typedef struct packed {
      logic waitForEventInstr;
      logic waitForInterruptInstr;
      logic eventFlag;
      logic interruptPending;
      logic handlerReturn;
   } lpmc_core_t;

endpackage

// ===== verilog/lpmc_controller.sv
`timescale 1ns/1ps
// Summary of operation
// - Backup keeps backup domain and slow oscillator running, core supplies off.
// - Software may disable the backup power-on-reset monitor.
// - Backup exits on any enabled wake source, pins, monitor, tamper or alarms.
// - Supply monitor wakes backup only on a present, falling io supply.
// - Writing one to regulator-off request enters backup mode.
// - Deep-sleep select one plus wait-for-event enters backup mode.
// - Backup entry shuts regulator, drives shutdown output low, removes core power.
// - Leaving backup restarts from reset, keeping only backup-area configuration.
// - Input supply loss never enters backup; shutdown output stays high.
// - Wait mode stops bus, peripheral and core clocks; power stays on.
// - Restart from wait mode completes within ten microseconds.
// - Wait-mode request bit enters wait; software then polls master clock ready.
// - Low-power select, deep-sleep zero and wait-for-event enter wait mode.
// - Flash select in wait: 0 standby, 1 deep power-down, 2 idle.
// - Wait exits on enabled fast wake pins, tamper, clock or timer alarm.
// - After wait, pin setup and fast RC frequency are kept.
// - Sleep stops only core clocks; enabled peripheral clocks keep running.
// - Interrupt wakes an interrupt-entered sleep; event wakes an event-entered sleep.
// - Sleep-on-handler-exit re-enters sleep on return from a handler.
// - Event pending before wait-for-event is consumed; no low-power entry.
// - Backup wake-up runs a sequence re-enabling core supply and logic.
// - Fast start-up restarts fast RC, switches master clock, re-enables core clock.
module lpmc_controller #(
   parameter int unsigned NUM_PINS = lpmc_pkg::NUM_WAKE_PINS
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire lpmc_pkg::lpmc_axi_req_t axiReq,
   output      lpmc_pkg::lpmc_axi_rsp_t axiRsp,
   input  wire lpmc_pkg::lpmc_wake_t   wakeIn,
   input  wire lpmc_pkg::lpmc_core_t   coreIn,
   input  wire logic                   inputSupplyLow,
   output      logic                   shutdownOutput,
   output      logic                   coreRegulatorOn,
   output      logic                   regulatorStandby,
   output      logic                   corePowerOn,
   output      logic                   backupDomainOn,
   output      logic                   backupPorEnable,
   output      logic                   slowOscRun,
   output      logic                   busMasterClockEn,
   output      logic                   coreClockEn,
   output      logic                   peripheralClockEn,
   output      logic                   fastRcRestart,
   output      logic                   eventConsumed,
   output      logic [1:0]             flashLowPowerSelect,
   output      logic                   flashLowPowerActive,
   output      logic                   systemReset
);

   localparam int unsigned WAKE_W = NUM_PINS + 5;
   localparam logic [15:0] RESTART_LAST = 16'(lpmc_pkg::WAIT_RESTART_CYC);
   localparam logic [15:0] POWERUP_LAST = 16'(lpmc_pkg::BACKUP_SEQ_CYC - 1);

   initial begin
      // The wake bundle carries a fixed number of pin lines; more cannot be served.
      if (NUM_PINS < 1 || NUM_PINS > lpmc_pkg::NUM_WAKE_PINS) begin
         $error("lpmc_controller: NUM_PINS must not exceed the wake pin count");
      end
   end

   typedef struct packed {
      lpmc_pkg::lpmc_state_t state;
      logic [15:0]           count;
      logic                  sleepByEvent;
      logic                  regOffReq;
      logic                  waitReq;
      logic                  lowPowerSelect;
      logic                  deepSleepSelect;
      logic                  sleep_on_handler_exit;
      logic                  porDisable;
      logic [1:0]            flashSel;
      logic [NUM_PINS-1:0]   pinEnable;
      logic [4:0]            srcEnable;
      logic                  masterClockReady;
      logic                  awTaken;
      logic                  wTaken;
      logic [7:0]            awAddr;
      logic [31:0]           wData;
      logic                  bValid;
      logic [1:0]            bResp;
      logic                  rValid;
      logic [31:0]           rData;
      logic [1:0]            rResp;
      logic [WAKE_W-1:0]     sync1;
      logic [WAKE_W-1:0]     sync2;
      logic [WAKE_W-1:0]     sync3;
      logic [WAKE_W-1:0]     stable;
      logic                  ioLowPrev;
   } lpmc_regs_t;

   lpmc_regs_t q;
   lpmc_regs_t d;

   // Known register map; anything else answers with a slave error.
   function automatic logic addrValid(input logic [7:0] a);
      return a == lpmc_pkg::ADDR_CONTROL || a == lpmc_pkg::ADDR_MODE ||
             a == lpmc_pkg::ADDR_WAKE_EN || a == lpmc_pkg::ADDR_STATUS ||
             a == lpmc_pkg::ADDR_SRCEN;
   endfunction

   logic [WAKE_W-1:0] rawWake;
   logic [WAKE_W-1:0] agreed;
   logic              pinWake;
   logic              ioFalling;
   logic              fastWake;
   logic              backupWake;
   logic              doWrite;
   logic              doRead;
   logic [7:0]        rdAddr;

   assign rawWake = {wakeIn.wakePin[NUM_PINS-1:0], wakeIn.forcedWakeupPin,
                     wakeIn.ioSupplyPresent & wakeIn.ioSupplyLow, wakeIn.tamperEvent,
                     wakeIn.rtcAlarm, wakeIn.rttAlarm};

   always_comb begin
      d = q;
      d.sync1 = rawWake;
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      agreed = (q.sync2 & q.sync3) | (q.stable & (q.sync2 | q.sync3));
      d.stable = agreed;
      d.ioLowPrev = agreed[3];

      pinWake = |(agreed[WAKE_W-1:5] & q.pinEnable);
      ioFalling = agreed[3] & ~q.ioLowPrev & q.srcEnable[lpmc_pkg::SRC_SM_BIT];
      fastWake = pinWake | (agreed[2] & q.srcEnable[lpmc_pkg::SRC_TAMPER_BIT]) |
                 (agreed[1] & q.srcEnable[lpmc_pkg::SRC_RTC_BIT]) |
                 (agreed[0] & q.srcEnable[lpmc_pkg::SRC_RTT_BIT]);
      backupWake = fastWake | ioFalling |
                   (agreed[4] & q.srcEnable[lpmc_pkg::SRC_FORCED_WAKEUP_PIN_BIT]);

      // AXI4-Lite write side: address and data may arrive in either order.
      if (axiReq.awvalid && !q.awTaken && !q.bValid) begin
         d.awTaken = 1'b1;
         d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !q.wTaken && !q.bValid) begin
         d.wTaken = 1'b1;
         d.wData = axiReq.wdata;
      end
      doWrite = q.awTaken && q.wTaken && !q.bValid;
      if (doWrite) begin
         d.awTaken = 1'b0;
         d.wTaken = 1'b0;
         d.bValid = 1'b1;
         d.bResp = addrValid(q.awAddr) ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
         case (q.awAddr)
            lpmc_pkg::ADDR_CONTROL: begin
               if (q.wData[lpmc_pkg::CTRL_REG_OFF_BIT]) begin
                  d.regOffReq = 1'b1;
               end
               if (q.wData[lpmc_pkg::CTRL_WAIT_REQ_BIT]) begin
                  d.waitReq = 1'b1;
                  d.masterClockReady = 1'b0;
               end
            end
            lpmc_pkg::ADDR_MODE: begin
               d.lowPowerSelect = q.wData[lpmc_pkg::MODE_LPSEL_BIT];
               d.deepSleepSelect = q.wData[lpmc_pkg::MODE_DEEP_BIT];
               d.sleep_on_handler_exit = q.wData[lpmc_pkg::MODE_ONEXIT_BIT];
               d.porDisable = q.wData[lpmc_pkg::MODE_PORDIS_BIT];
               d.flashSel = q.wData[lpmc_pkg::MODE_FLASH_LOW_POWER_SELECT_LSB +: 2];
            end
            lpmc_pkg::ADDR_WAKE_EN: d.pinEnable = q.wData[NUM_PINS-1:0];
            lpmc_pkg::ADDR_SRCEN: d.srcEnable = q.wData[4:0];
            default: begin
            end
         endcase
      end
      if (q.bValid && axiReq.bready) begin
         d.bValid = 1'b0;
      end

      doRead = axiReq.arvalid && !q.rValid;
      rdAddr = axiReq.araddr;
      if (doRead) begin
         d.rValid = 1'b1;
         d.rResp = addrValid(rdAddr) ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
         d.rData = '0;
         case (rdAddr)
            lpmc_pkg::ADDR_CONTROL: d.rData[lpmc_pkg::CTRL_WAIT_REQ_BIT] = q.waitReq;
            lpmc_pkg::ADDR_MODE: d.rData[7:0] = {2'h0, q.flashSel, q.porDisable,
                                   q.sleep_on_handler_exit, q.deepSleepSelect, q.lowPowerSelect};
            lpmc_pkg::ADDR_WAKE_EN: d.rData[NUM_PINS-1:0] = q.pinEnable;
            lpmc_pkg::ADDR_STATUS: d.rData[3:0] = {q.state, q.masterClockReady};
            lpmc_pkg::ADDR_SRCEN: d.rData[4:0] = q.srcEnable;
            default: d.rData = '0;
         endcase
      end
      if (q.rValid && axiReq.rready) begin
         d.rValid = 1'b0;
      end

      case (q.state)
         lpmc_pkg::ST_ACTIVE: begin
            d.count = '0;
            // Input supply loss is deliberately not a trigger here.
            if (q.regOffReq) begin
               d.state = lpmc_pkg::ST_BACKUP;
            end else if (q.waitReq) begin
               d.state = lpmc_pkg::ST_WAIT;
            end else if (coreIn.waitForEventInstr && coreIn.eventFlag) begin
               d.state = lpmc_pkg::ST_ACTIVE;
            end else if (coreIn.waitForEventInstr && q.deepSleepSelect) begin
               d.state = lpmc_pkg::ST_BACKUP;
            end else if (coreIn.waitForEventInstr && q.lowPowerSelect) begin
               d.state = lpmc_pkg::ST_WAIT;
            end else if (coreIn.waitForEventInstr || coreIn.waitForInterruptInstr ||
                         (coreIn.handlerReturn && q.sleep_on_handler_exit)) begin
               d.state = lpmc_pkg::ST_SLEEP;
               d.sleepByEvent = coreIn.waitForEventInstr;
            end
         end
         lpmc_pkg::ST_SLEEP: begin
            if (q.sleepByEvent ? (fastWake || coreIn.eventFlag) : coreIn.interruptPending) begin
               d.state = lpmc_pkg::ST_ACTIVE;
            end
         end
         lpmc_pkg::ST_WAIT: begin
            d.count = '0;
            if (fastWake) begin
               d.state = lpmc_pkg::ST_RESTART;
            end
         end
         lpmc_pkg::ST_RESTART: begin
            d.count = q.count + 16'h0001;
            if (q.count == RESTART_LAST) begin
               // Pin enables and mode settings are left untouched across wait.
               d.state = lpmc_pkg::ST_ACTIVE;
               d.waitReq = 1'b0;
               d.masterClockReady = 1'b1;
            end
         end
         lpmc_pkg::ST_BACKUP: begin
            d.count = '0;
            if (backupWake) begin
               d.state = lpmc_pkg::ST_POWERUP;
            end
         end
         lpmc_pkg::ST_POWERUP: begin
            d.count = q.count + 16'h0001;
            if (q.count == POWERUP_LAST) begin
               // Core-side settings fall back to reset; backup-area settings stay.
               d.state = lpmc_pkg::ST_ACTIVE;
               d.regOffReq = 1'b0;
               d.waitReq = 1'b0;
               d.lowPowerSelect = 1'b0;
               d.deepSleepSelect = 1'b0;
               d.sleep_on_handler_exit = 1'b0;
               d.flashSel = lpmc_pkg::FLASH_STANDBY;
               d.masterClockReady = 1'b1;
            end
         end
         default: d.state = lpmc_pkg::ST_ACTIVE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
         q.state <= lpmc_pkg::ST_ACTIVE;
         q.masterClockReady <= 1'b1;
         q.flashSel <= lpmc_pkg::FLASH_STANDBY;
      end else begin
         q <= d;
      end
   end

   logic inBackup;
   logic inWaitClass;
   assign inBackup = q.state == lpmc_pkg::ST_BACKUP || q.state == lpmc_pkg::ST_POWERUP;
   assign inWaitClass = q.state == lpmc_pkg::ST_WAIT;

   assign axiRsp.awready = !q.awTaken && !q.bValid;
   assign axiRsp.wready = !q.wTaken && !q.bValid;
   assign axiRsp.bvalid = q.bValid;
   assign axiRsp.bresp = q.bResp;
   assign axiRsp.arready = !q.rValid;
   assign axiRsp.rvalid = q.rValid;
   assign axiRsp.rdata = q.rData;
   assign axiRsp.rresp = q.rResp;

   assign shutdownOutput = q.state != lpmc_pkg::ST_BACKUP;
   assign coreRegulatorOn = !inBackup;
   assign corePowerOn = !inBackup;
   assign regulatorStandby = inWaitClass;
   assign backupDomainOn = 1'b1;
   assign slowOscRun = 1'b1;
   assign backupPorEnable = !q.porDisable;
   assign busMasterClockEn = !inBackup && !inWaitClass;
   assign peripheralClockEn = !inBackup && !inWaitClass;
   assign coreClockEn = q.state == lpmc_pkg::ST_ACTIVE;
   assign fastRcRestart = q.state == lpmc_pkg::ST_RESTART;
   assign eventConsumed = q.state == lpmc_pkg::ST_ACTIVE && coreIn.waitForEventInstr &&
                          coreIn.eventFlag && !q.regOffReq && !q.waitReq;
   assign flashLowPowerSelect = q.flashSel;
   assign flashLowPowerActive = inWaitClass && q.flashSel != lpmc_pkg::FLASH_IDLE;
   assign systemReset = q.state == lpmc_pkg::ST_POWERUP;

endmodule

// ===== testbench/lpmc_controller_monitor.sv
`timescale 1ns/1ps
module lpmc_controller_monitor #(
   parameter int unsigned NUM_PINS = 16
) (
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire lpmc_pkg::lpmc_core_t coreIn,
   input wire logic                 shutdownOutput,
   input wire logic                 coreRegulatorOn,
   input wire logic                 regulatorStandby,
   input wire logic                 corePowerOn,
   input wire logic                 backupDomainOn,
   input wire logic                 slowOscRun,
   input wire logic                 busMasterClockEn,
   input wire logic                 coreClockEn,
   input wire logic                 peripheralClockEn,
   input wire logic                 fastRcRestart,
   input wire logic                 eventConsumed,
   input wire logic [1:0]           flashLowPowerSelect,
   input wire logic                 flashLowPowerActive,
   input wire logic                 systemReset
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // The restart must hand the core its clock back inside the ten microsecond window.
   sequence s_restart_done;
      !coreClockEn ##[1:1000] coreClockEn;
   endsequence
   a_backup_domain_on: assert property (backupDomainOn && slowOscRun)
      else $error("backup domain or slow oscillator stopped");
   a_backup_power_off: assert property (!shutdownOutput |-> !coreRegulatorOn && !corePowerOn)
      else $error("core supply left on while shutdown output is low");
   a_wait_clocks_off: assert property (regulatorStandby |->
      !busMasterClockEn && !peripheralClockEn && !coreClockEn && corePowerOn)
      else $error("wait state clocks or power wrong");
   a_restart_bounded: assert property ($rose(fastRcRestart) |-> s_restart_done)
      else $error("restart from wait too slow");
   a_flash_in_wait: assert property (flashLowPowerActive ==
      (regulatorStandby && flashLowPowerSelect != lpmc_pkg::FLASH_IDLE))
      else $error("flash low power state does not follow select");
   a_event_consumed: assert property (eventConsumed |->
      (coreIn.waitForEventInstr && coreIn.eventFlag) ##1 coreClockEn)
      else $error("event consumption wrong");
   a_powerup_after_backup: assert property ($rose(systemReset) |->
      !$past(shutdownOutput) && !corePowerOn)
      else $error("power-up sequence not entered from backup");
   a_sleep_keeps_periph: assert property ((!coreClockEn && shutdownOutput && !regulatorStandby
      && !fastRcRestart && !systemReset) |-> peripheralClockEn)
      else $error("peripheral clock stopped in sleep");
endmodule
bind lpmc_controller lpmc_controller_monitor #(.NUM_PINS(NUM_PINS)) lpmc_controller_monitor_inst (
   .ref_clk(ref_clk), .rst(rst), .coreIn(coreIn), .shutdownOutput(shutdownOutput),
   .coreRegulatorOn(coreRegulatorOn), .regulatorStandby(regulatorStandby),
   .corePowerOn(corePowerOn), .backupDomainOn(backupDomainOn), .slowOscRun(slowOscRun),
   .busMasterClockEn(busMasterClockEn), .coreClockEn(coreClockEn),
   .peripheralClockEn(peripheralClockEn), .fastRcRestart(fastRcRestart),
   .eventConsumed(eventConsumed), .flashLowPowerSelect(flashLowPowerSelect),
   .flashLowPowerActive(flashLowPowerActive), .systemReset(systemReset));

// ===== testbench/lpmc_far_side.sv
`timescale 1ns/1ps
module lpmc_far_side (
   input  wire logic            ref_clk,
   output lpmc_pkg::lpmc_wake_t wake,
   output lpmc_pkg::lpmc_core_t core
);
   initial begin
      wake = '0;
      core = '0;
   end
   // Wake lines are asynchronous levels; callers hold them for several cycles because
   // the block filters them through a synchroniser.
   task automatic wake_set(input int idx, input logic val);
      @(posedge ref_clk);
      wake[idx] <= val;
   endtask
   // The software side has already put flash wait states to zero and the fast RC
   // oscillator on the main clock before any wait request or instruction strobe.
   task automatic core_set(input int idx, input logic val);
      @(posedge ref_clk);
      core[idx] <= val;
   endtask
endmodule

// ===== testbench/tb_lpmc_controller.sv
`timescale 1ns/1ps
module tb_lpmc_controller;
   logic                    ref_clk;
   logic                    rst;
   logic                    inputSupplyLow;
   lpmc_pkg::lpmc_axi_req_t axiReq;
   lpmc_pkg::lpmc_axi_rsp_t axiRsp;
   lpmc_pkg::lpmc_wake_t    wakeIn;
   lpmc_pkg::lpmc_core_t    coreIn;
   logic                    shutdownOutput, coreRegulatorOn, regulatorStandby, corePowerOn;
   logic                    backupDomainOn, slowOscRun, busMasterClockEn, coreClockEn;
   logic                    peripheralClockEn, fastRcRestart, eventConsumed;
   logic                    flashLowPowerActive, systemReset, backupPorEnable;
   logic [1:0]              flashLowPowerSelect;
   int                      errors = 0;
   int                      cmpCount = 0;
   int                      cycles = 0;

   lpmc_controller lpmc_controller_inst (.ref_clk(ref_clk), .rst(rst), .axiReq(axiReq),
      .axiRsp(axiRsp), .wakeIn(wakeIn), .coreIn(coreIn), .inputSupplyLow(inputSupplyLow),
      .shutdownOutput(shutdownOutput), .coreRegulatorOn(coreRegulatorOn),
      .regulatorStandby(regulatorStandby), .corePowerOn(corePowerOn),
      .backupDomainOn(backupDomainOn), .backupPorEnable(backupPorEnable),
      .slowOscRun(slowOscRun), .busMasterClockEn(busMasterClockEn),
      .coreClockEn(coreClockEn), .peripheralClockEn(peripheralClockEn),
      .fastRcRestart(fastRcRestart), .eventConsumed(eventConsumed),
      .flashLowPowerSelect(flashLowPowerSelect), .flashLowPowerActive(flashLowPowerActive),
      .systemReset(systemReset));
   lpmc_far_side lpmc_far_side_inst (.ref_clk(ref_clk), .wake(wakeIn), .core(coreIn));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Ready is sampled at the falling edge, where it is settled for the next rising edge.
   task automatic axi_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                           output logic [31:0] rdat, output logic [1:0] resp);
      logic aw, w, ar, done;
      done = 1'b0;
      @(posedge ref_clk);
      axiReq <= '{awaddr: addr, awvalid: wr, wdata: data, wstrb: 4'hF, wvalid: wr,
                  bready: wr, araddr: addr, arvalid: !wr, rready: !wr};
      while (!done) begin
         @(negedge ref_clk);
         aw = axiReq.awvalid & axiRsp.awready;
         w = axiReq.wvalid & axiRsp.wready;
         ar = axiReq.arvalid & axiRsp.arready;
         done = wr ? axiRsp.bvalid : axiRsp.rvalid;
         resp = wr ? axiRsp.bresp : axiRsp.rresp;
         rdat = axiRsp.rdata;
         @(posedge ref_clk);
         if (aw) axiReq.awvalid <= 1'b0;
         if (w) axiReq.wvalid <= 1'b0;
         if (ar) axiReq.arvalid <= 1'b0;
      end
      axiReq.bready <= 1'b0;
      axiReq.rready <= 1'b0;
      check(32'(done), 32'h1);
   endtask
   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic [1:0]  r;
      axi_xfer(1'b1, addr, data, d, r);
      check(32'(r), 32'(lpmc_pkg::RESP_OKAY));
   endtask
   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_xfer(1'b0, addr, 32'h0, d, r);
      check(d, exp);
   endtask
   task automatic pulse(input int idx);
      lpmc_far_side_inst.core_set(idx, 1'b1);
      lpmc_far_side_inst.core_set(idx, 1'b0);
   endtask

   task automatic t_basic();
      logic [31:0] d;
      logic [1:0]  r;
      rd_chk(8'h0C, 32'h1);
      axi_xfer(1'b1, 8'h14, 32'hFFFF_FFFF, d, r);
      check(32'(r), 32'(lpmc_pkg::RESP_SLVERR));
      axi_xfer(1'b0, 8'h14, 32'h0, d, r);
      check(32'(r), 32'(lpmc_pkg::RESP_SLVERR));
      check(d, 32'h0);
      inputSupplyLow <= 1'b1;
      repeat (20) @(negedge ref_clk);
      check(32'({shutdownOutput, backupDomainOn, slowOscRun}), 32'h7);
      @(posedge ref_clk);
      inputSupplyLow <= 1'b0;
      $display("basic test done");
   endtask
   task automatic t_sleep();
      int n;
      pulse(3);
      @(negedge ref_clk);
      check(32'({coreClockEn, peripheralClockEn, busMasterClockEn}), 32'h3);
      rd_chk(8'h0C, 32'h3);
      lpmc_far_side_inst.core_set(1, 1'b1);
      for (n = 0; n < 10 && !coreClockEn; n++) @(negedge ref_clk);
      check(32'(coreClockEn), 32'h1);
      lpmc_far_side_inst.core_set(1, 1'b0);
      pulse(4);
      @(negedge ref_clk);
      check(32'(coreClockEn), 32'h0);
      lpmc_far_side_inst.core_set(2, 1'b1);
      for (n = 0; n < 10 && !coreClockEn; n++) @(negedge ref_clk);
      check(32'(coreClockEn), 32'h1);
      lpmc_far_side_inst.core_set(4, 1'b1);
      @(negedge ref_clk);
      check(32'(eventConsumed), 32'h1);
      lpmc_far_side_inst.core_set(4, 1'b0);
      @(negedge ref_clk);
      check(32'(coreClockEn), 32'h1);
      lpmc_far_side_inst.core_set(2, 1'b0);
      wr(8'h04, 32'h4);
      pulse(0);
      @(negedge ref_clk);
      check(32'(coreClockEn), 32'h0);
      lpmc_far_side_inst.core_set(1, 1'b1);
      for (n = 0; n < 10 && !coreClockEn; n++) @(negedge ref_clk);
      lpmc_far_side_inst.core_set(1, 1'b0);
      wr(8'h04, 32'h0);
      $display("sleep test done");
   endtask
   task automatic t_wait();
      int src[4] = '{6, 4, 3, 2};
      int i;
      int n;
      wr(8'h10, 32'h1C);
      wr(8'h08, 32'h1);
      for (i = 0; i < 4; i++) begin
         wr(8'h04, (32'(i % 3) << 4) | 32'(i == 3));
         if (i == 3) pulse(4);
         else wr(8'h00, 32'h2);
         for (n = 0; n < 20 && !regulatorStandby; n++) @(negedge ref_clk);
         check(32'({regulatorStandby, busMasterClockEn, coreClockEn, corePowerOn}), 32'h9);
         check(32'({flashLowPowerSelect, flashLowPowerActive}), 32'((i % 3) * 2 + (i % 3 != 2)));
         lpmc_far_side_inst.wake_set(7, 1'b1);
         repeat (8) @(negedge ref_clk);
         check(32'(regulatorStandby), 32'h1);
         lpmc_far_side_inst.wake_set(7, 1'b0);
         lpmc_far_side_inst.wake_set(src[i], 1'b1);
         for (n = 0; n < 20 && !fastRcRestart; n++) @(negedge ref_clk);
         check(32'({fastRcRestart, busMasterClockEn, coreClockEn}), 32'h6);
         for (n = 0; n < 1100 && !coreClockEn; n++) @(negedge ref_clk);
         check(32'(n <= 1000), 32'h1);
         lpmc_far_side_inst.wake_set(src[i], 1'b0);
         rd_chk(8'h0C, 32'h1);
      end
      wr(8'h04, 32'h0);
      $display("wait test done");
   endtask
   task automatic t_backup();
      int n;
      wr(8'h04, 32'h8);
      @(negedge ref_clk);
      check(32'(backupPorEnable), 32'h0);
      wr(8'h10, 32'h1F);
      lpmc_far_side_inst.wake_set(1, 1'b1);
      lpmc_far_side_inst.wake_set(0, 1'b1);
      repeat (6) @(negedge ref_clk);
      wr(8'h00, 32'h1);
      for (n = 0; n < 10 && shutdownOutput; n++) @(negedge ref_clk);
      check(32'({shutdownOutput, coreRegulatorOn, corePowerOn, backupDomainOn}), 32'h1);
      lpmc_far_side_inst.wake_set(0, 1'b0);
      repeat (10) @(negedge ref_clk);
      check(32'(shutdownOutput), 32'h0);
      lpmc_far_side_inst.wake_set(5, 1'b1);
      for (n = 0; n < 20 && !systemReset; n++) @(negedge ref_clk);
      check(32'({systemReset, shutdownOutput, corePowerOn}), 32'h6);
      lpmc_far_side_inst.wake_set(5, 1'b0);
      for (n = 0; n < 40 && !coreClockEn; n++) @(negedge ref_clk);
      rd_chk(8'h04, 32'h8);
      rd_chk(8'h10, 32'h1F);
      wr(8'h04, 32'hA);
      pulse(4);
      for (n = 0; n < 10 && shutdownOutput; n++) @(negedge ref_clk);
      check(32'(shutdownOutput), 32'h0);
      lpmc_far_side_inst.wake_set(0, 1'b1);
      for (n = 0; n < 20 && !systemReset; n++) @(negedge ref_clk);
      check(32'(systemReset), 32'h1);
      for (n = 0; n < 40 && !coreClockEn; n++) @(negedge ref_clk);
      check(32'(coreClockEn), 32'h1);
      $display("backup test done");
   endtask

   initial begin
      rst = 1'b1;
      inputSupplyLow = 1'b0;
      axiReq = '0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_basic();
      t_sleep();
      t_wait();
      t_backup();
      report_and_stop();
   end
endmodule
